// ===== design/tpw_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH
`define TPW_ADDR_W 4
`define TPW_OFS_MODE 4'h0
`define TPW_OFS_PERIOD 4'h1
`define TPW_OFS_DUTY 4'h2
`define TPW_OFS_IRQ_STAT 4'h3
`define TPW_OFS_IRQ_MASK 4'h4
`define TPW_OFS_STATUS 4'h5
`define TPW_OFS_COUNT 4'h6
`define TPW_BIT_RUN 7
`define TPW_BIT_CKS_HI 6
`define TPW_BIT_CKS_LO 4
`define TPW_BIT_MODE_HI 3
`define TPW_BIT_MODE_LO 2
`define TPW_BIT_IDLE 1
`define TPW_BIT_OE 0
`define TPW_MODE_RESET 8'h00
`define TPW_CMP_RESET 8'h00
`define TPW_BUF_SETTLE 2'h3
`define TPW_IRQ_PERIOD 0
`define TPW_IRQ_DUTY_LOAD 1
`endif

// ===== design/tpw_pkg.sv
// Types shared by the PWM timer
package tpw_pkg;
    typedef enum logic [1:0] {TPW_STOP, TPW_ARM, TPW_CMP_PERIOD,
        TPW_CMP_DUTY} tpw_state_e;
    typedef struct packed {
        logic run;
        logic [2:0] clk_sel;
        logic [1:0] op_mode;
        logic idle_level;
        logic out_en;
    } tpw_mode_s;
endpackage

// ===== design/tpw_timer.sv
// PWM output timer with register port and interrupt
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tpw_regs.svh"

////////////////////////////////////////////////////////////////////////
module tpw_timer #(
    parameter int CNT_W = 8,
    parameter int PRE_W = 12
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    // Low-speed tick for the slow clock select
    input wire logic slow_tick,
    // Register port
    input wire logic [`TPW_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pulse pin and interrupts
    output logic pulse_out_pin,
    output logic pulse_out_pin_oe,
    output logic period_match_irq,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // State
    tpw_pkg::tpw_mode_s mode_ff, nxt_mode;
    tpw_pkg::tpw_state_e state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] period_ff, nxt_period;
    logic [CNT_W-1:0] duty_ff, nxt_duty;
    logic [CNT_W-1:0] duty_buf_ff, nxt_duty_buf;
    logic buf_full_ff, nxt_buf_full;
    logic [1:0] settle_ff, nxt_settle;
    logic [PRE_W-1:0] pre_ff, nxt_pre;
    logic out_ff, nxt_out;
    logic pm_irq_ff, nxt_pm_irq;
    logic [1:0] stat_ff, nxt_stat;
    logic [1:0] mask_ff, nxt_mask;
    logic [7:0] rdata_ff, nxt_rdata;
    logic tick;
    logic period_hit;
    logic duty_hit;
    logic buf_ready;
    logic duty_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Count clock select from free prescaler or slow tick
    always_comb
    begin
        nxt_pre = pre_ff + PRE_W'(1);
        unique case (mode_ff.clk_sel)
            3'h0: tick = 1'b1;
            3'h1: tick = (pre_ff[1:0] == 2'h3);
            3'h2: tick = (pre_ff[3:0] == 4'hf);
            3'h3: tick = (pre_ff[5:0] == 6'h3f);
            3'h4: tick = (pre_ff == {PRE_W{1'b1}});
            3'h5: tick = slow_tick;
            default: tick = 1'b0; // Prohibited selects never count
        endcase
    end

    // Compares only act in the matching phase
    assign period_hit = (state_ff == tpw_pkg::TPW_CMP_PERIOD) && tick &&
        hit(cnt_ff, period_ff);
    assign duty_hit = (state_ff == tpw_pkg::TPW_CMP_DUTY) && tick &&
        hit(cnt_ff, duty_ff);
    // Buffered duty may load only once it has settled
    assign buf_ready = buf_full_ff && (settle_ff == `TPW_BUF_SETTLE);
    // Duty writes pick between direct load and the buffer
    assign duty_wr = reg_wr && (reg_addr == `TPW_OFS_DUTY);

    ////////////////////////////////////////////////////////////////////
    // Timer core next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        nxt_pm_irq = 1'b0;
        nxt_duty = duty_ff;
        nxt_buf_full = buf_full_ff;
        nxt_settle = settle_ff;
        // Settle counter measures count clocks since the write
        if (buf_full_ff && tick && settle_ff != `TPW_BUF_SETTLE)
        begin
            nxt_settle = settle_ff + 2'h1;
        end
        unique case (state_ff)
            tpw_pkg::TPW_STOP:
            begin
                nxt_cnt = '0;
                nxt_out = 1'b0;
                if (mode_ff.run)
                begin
                    nxt_state = tpw_pkg::TPW_ARM;
                end
            end
            tpw_pkg::TPW_ARM:
            begin
                // The first count clock is swallowed here
                if (tick)
                begin
                    nxt_state = tpw_pkg::TPW_CMP_PERIOD;
                end
            end
            tpw_pkg::TPW_CMP_PERIOD:
            begin
                if (period_hit)
                begin
                    nxt_cnt = '0;
                    nxt_pm_irq = 1'b1;
                    nxt_out = 1'b1;
                    nxt_state = tpw_pkg::TPW_CMP_DUTY;
                end
                else if (tick)
                begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
            end
            tpw_pkg::TPW_CMP_DUTY:
            begin
                // Counter runs on through the duty match
                if (tick)
                begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
                if (duty_hit)
                begin
                    nxt_out = 1'b0;
                    nxt_state = tpw_pkg::TPW_CMP_PERIOD;
                    // Only a settled buffer loads; otherwise wait
                    if (buf_ready)
                    begin
                        nxt_duty = duty_buf_ff;
                        nxt_buf_full = 1'b0;
                    end
                end
            end
        endcase
        // Stop overrides state, count, period irq and output at once
        if (!mode_ff.run)
        begin
            nxt_state = tpw_pkg::TPW_STOP;
            nxt_cnt = '0;
            nxt_pm_irq = 1'b0;
            nxt_out = 1'b0;
        end
        // Stopped timer loads duty straight through, as a restart needs
        if (duty_wr)
        begin
            if (state_ff == tpw_pkg::TPW_STOP && !mode_ff.run)
            begin
                nxt_duty = reg_wdata;
                // A stale buffered value must not load after restart
                nxt_buf_full = 1'b0;
            end
            else
            begin
                nxt_buf_full = 1'b1;
                nxt_settle = 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes, sticky status and read data
    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_period = period_ff;
        nxt_duty_buf = duty_buf_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        nxt_rdata = 8'h00;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `TPW_OFS_MODE:
                begin
                    // Only run may change while running
                    if (mode_ff.run)
                    begin
                        nxt_mode.run = reg_wdata[`TPW_BIT_RUN];
                    end
                    else
                    begin
                        nxt_mode = tpw_pkg::tpw_mode_s'(reg_wdata);
                    end
                end
                `TPW_OFS_PERIOD:
                begin
                    // A cycle change mid-count would tear the pulse
                    if (!mode_ff.run)
                    begin
                        nxt_period = reg_wdata;
                    end
                end
                `TPW_OFS_DUTY: nxt_duty_buf = reg_wdata;
                `TPW_OFS_IRQ_STAT: nxt_stat = stat_ff & ~reg_wdata[1:0];
                `TPW_OFS_IRQ_MASK: nxt_mask = reg_wdata[1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle
        if (period_hit && mode_ff.run)
        begin
            nxt_stat[`TPW_IRQ_PERIOD] = 1'b1;
        end
        if (duty_hit && mode_ff.run && buf_ready)
        begin
            nxt_stat[`TPW_IRQ_DUTY_LOAD] = 1'b1;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                `TPW_OFS_MODE: nxt_rdata = mode_ff;
                `TPW_OFS_PERIOD: nxt_rdata = period_ff;
                `TPW_OFS_DUTY: nxt_rdata = duty_ff;
                `TPW_OFS_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
                `TPW_OFS_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
                `TPW_OFS_STATUS: nxt_rdata = {5'h00, buf_full_ff,
                    state_ff};
                `TPW_OFS_COUNT: nxt_rdata = cnt_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers; clock enable freezes all
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_ff <= tpw_pkg::tpw_mode_s'(`TPW_MODE_RESET);
            state_ff <= tpw_pkg::TPW_STOP;
            cnt_ff <= '0;
            period_ff <= `TPW_CMP_RESET;
            duty_ff <= `TPW_CMP_RESET;
            duty_buf_ff <= `TPW_CMP_RESET;
            buf_full_ff <= 1'b0;
            settle_ff <= 2'h0;
            pre_ff <= '0;
            out_ff <= 1'b0;
            pm_irq_ff <= 1'b0;
            stat_ff <= 2'h0;
            mask_ff <= 2'h0;
            rdata_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            mode_ff <= nxt_mode;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            period_ff <= nxt_period;
            duty_ff <= nxt_duty;
            duty_buf_ff <= nxt_duty_buf;
            buf_full_ff <= nxt_buf_full;
            settle_ff <= nxt_settle;
            pre_ff <= nxt_pre;
            out_ff <= nxt_out;
            pm_irq_ff <= nxt_pm_irq;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs; stop gates period_match_irq and pin at once, not irq
    assign reg_rdata = rdata_ff;
    // Core keeps an active flag, so a new idle level cannot fake an edge
    assign pulse_out_pin = mode_ff.idle_level ^ (mode_ff.run & out_ff);
    assign pulse_out_pin_oe = mode_ff.out_en;
    assign period_match_irq = pm_irq_ff & mode_ff.run;
    assign irq = |(stat_ff & mask_ff);

endmodule // tpw_timer

// ===== test/tpw_chk_assertions.sv
// Port assertions for the PWM timer
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tpw_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [`TPW_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pin and interrupts
    input wire logic pulse_out_pin,
    input wire logic pulse_out_pin_oe,
    input wire logic period_match_irq,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Shadow of run, idle and mask; idle locks while running
    logic [2:0] sh_ff;
    logic [2:0] nxt_sh;
    wire mwr = reg_wr && reg_addr == `TPW_OFS_MODE;
    wire kwr = reg_wr && reg_addr == `TPW_OFS_IRQ_MASK;
    always_comb
    begin
        nxt_sh = sh_ff;
        if (mwr)
            nxt_sh[2] = reg_wdata[`TPW_BIT_RUN];
        if (mwr && !sh_ff[2])
            nxt_sh[1] = reg_wdata[`TPW_BIT_IDLE];
        if (kwr)
            nxt_sh[0] = reg_wdata[`TPW_IRQ_PERIOD];
    end
    always_ff @(posedge clk_sys)
        sh_ff <= rst ? 3'h0 : nxt_sh;
    ////////////////////////////////////////
    sequence s_stop;
        mwr && !reg_wdata[`TPW_BIT_RUN];
    endsequence
    sequence s_start;
        $rose(sh_ff[2]);
    endsequence
    a_unmapped_rd: assert property (reg_rd && reg_addr > `TPW_OFS_COUNT
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_stop_quiet: assert property (s_stop |=> !period_match_irq)
        else $error("irq after stop");
    a_idle_stop: assert property (!sh_ff[2] |-> pulse_out_pin == sh_ff[1])
        else $error("pin not idle while stopped");
    a_start_idle: assert property (s_start
        |-> (pulse_out_pin == sh_ff[1]) [*3]) else $error("early pulse");
    a_match_act: assert property (period_match_irq
        |-> pulse_out_pin != sh_ff[1]) else $error("pin idle at match");
    a_irq_pulse: assert property (period_match_irq
        |=> !period_match_irq) else $error("irq longer than one cycle");
    a_oe_follow: assert property (mwr && !sh_ff[2]
        |=> pulse_out_pin_oe == $past(reg_wdata[`TPW_BIT_OE]))
        else $error("output enable wrong");
    a_irq_mask: assert property (period_match_irq && sh_ff[0]
        |-> ##[0:2] irq) else $error("unmasked event without irq");
endmodule // tpw_chk

// ===== test/tpw_sink.sv
// Load on the pulse pin: measures period and active width
`timescale 1ns/1ps
module tpw_sink (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pin as the load sees it
    input wire logic pin,
    input wire logic oe,
    input wire logic idle_lvl,
    // Last full cycle, in clk_sys cycles
    output logic vld,
    output logic [15:0] per,
    output logic [15:0] wid
);
    logic act_ff, seen_ff;
    logic [15:0] pc_ff, wc_ff;
    // Undriven pin carries nothing
    wire act = oe && (pin != idle_lvl);
    wire rise = act && !act_ff;
    // Count from one rising edge to the next
    always_ff @(posedge clk_sys)
    begin
        act_ff <= act && !rst;
        seen_ff <= !rst && oe && (seen_ff || rise);
        vld <= rise && seen_ff && !rst;
        pc_ff <= rise ? 16'h0001 : pc_ff + 16'h0001;
        wc_ff <= rise ? 16'h0001 : wc_ff + {15'h0000, act};
        if (rise)
        begin
            per <= pc_ff;
            wid <= wc_ff;
        end
    end
endmodule // tpw_sink

// ===== test/testbench.sv
// Self-checking bench for the PWM timer
`timescale 1ns/1ps
`include "tpw_regs.svh"
module testbench;
    logic clk_sys = 1'h0, rst = 1'h1, clk_en = 1'h1, slow_tick = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'h0, reg_rd = 1'h0, rd_q = 1'h0;
    logic pin, oe, pmi, irq, vld, idle = 1'h0;
    logic [15:0] per, wid;
    logic [2:0] sc = 3'h0;
    logic [32:0] exp_q[$];
    int n_mismatch = 0, n_checks = 0, div[6] = '{1, 4, 16, 64, 4096, 5};
    int n, m;
    always #20 clk_sys = ~clk_sys;
    // Slow tick every fifth cycle
    always @(posedge clk_sys) sc <= (sc == 3'h4) ? 3'h0 : sc + 3'h1;
    always @(posedge clk_sys) slow_tick <= (sc == 3'h4);
    tpw_timer i_dut (.clk_sys, .rst, .clk_en, .slow_tick, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pulse_out_pin(pin),
        .pulse_out_pin_oe(oe), .period_match_irq(pmi), .irq);
    tpw_sink i_sink (.clk_sys, .rst, .pin, .oe, .idle_lvl(idle), .vld,
        .per, .wid);
    ////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        reg_rd <= 1'h0;
        @(posedge clk_sys);
    endtask
    // Read notes carry the interrupt level beside the data
    task automatic rd(input logic [3:0] a, input logic [7:0] d,
        input logic q);
        exp_q.push_back({1'h0, 23'h00_0000, q, d});
        reg_addr <= a;
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
    endtask
    // Bounded wait for a period match or for the notes to drain
    task automatic hold(input bit for_irq);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        for (int k = 0; k < 40000; k++)
        begin
            @(posedge clk_sys);
            if (for_irq ? pmi === 1'h1 : exp_q.size() == 0)
                return;
        end
        n_mismatch++;
        end_sim();
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Results are matched against the oldest note; strays are dropped,
    // and a late pulse after a stop never eats a read note
    task automatic take(input logic k, input logic [31:0] got);
        logic [32:0] e;
        if (exp_q.size() == 0 || (k && !exp_q[0][32]))
            return;
        e = exp_q.pop_front();
        n_checks++;
        if ({k, got} !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %h expected %h", $time, got, e);
        end
    endtask
    always @(posedge clk_sys)
    begin
        rd_q <= reg_rd;
        if (rd_q === 1'h1) take(1'h0, {23'h00_0000, irq, reg_rdata});
        if (vld === 1'h1) take(1'h1, {per, wid});
    end
    ////////////////////////////////////////
    initial
    begin
        void'($urandom(93));
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        for (int a = 0; a < 8; a++) rd(4'(a), 8'h00, 1'h0);
        // Every count clock, random cycle, duty and idle level; select 4 fixes period 1, duty 0
        for (int c = 0; c < 6; c++)
        begin
            n = (c == 4) ? 1 : 1 + $urandom % 6;
            m = $urandom % n;
            idle = 1'($urandom);
            wr(`TPW_OFS_PERIOD, 8'(n));
            wr(`TPW_OFS_DUTY, 8'(m));
            wr(`TPW_OFS_MODE, {1'h1, 3'(c), 2'h2, idle, 1'h1});
            repeat (2) exp_q.push_back({1'h1, 16'((n + 1) * div[c]),
                16'((m + 1) * div[c])});
            hold(0);
            wr(`TPW_OFS_MODE, 8'h00);
            wr(`TPW_OFS_MODE, 8'h00);
            rd(`TPW_OFS_COUNT, 8'h00, 1'h0);
            rd(`TPW_OFS_DUTY, 8'(m), 1'h0);
        end
        // Duty written just before its match lands a period late
        idle = 1'h0;
        wr(`TPW_OFS_IRQ_STAT, 8'h03);
        wr(`TPW_OFS_IRQ_MASK, 8'h01);
        wr(`TPW_OFS_PERIOD, 8'h07);
        wr(`TPW_OFS_DUTY, 8'h00);
        wr(`TPW_OFS_MODE, 8'h99);
        hold(1);
        wr(`TPW_OFS_DUTY, 8'h04);
        reg_wr <= 1'h0;
        @(posedge clk_sys);
        exp_q.push_back({1'h1, 16'h0020, 16'h0004});
        exp_q.push_back({1'h1, 16'h0020, 16'h0004});
        exp_q.push_back({1'h1, 16'h0020, 16'h0014});
        hold(0);
        wr(`TPW_OFS_MODE, 8'h00);
        rd(`TPW_OFS_DUTY, 8'h04, 1'h1);
        rd(`TPW_OFS_IRQ_STAT, 8'h03, 1'h1);
        wr(`TPW_OFS_IRQ_STAT, 8'h03);
        wr(`TPW_OFS_IRQ_MASK, 8'h00);
        rd(`TPW_OFS_IRQ_STAT, 8'h00, 1'h0);
        hold(0);
        end_sim();
    end
endmodule // testbench
bind tpw_timer tpw_chk i_chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pulse_out_pin, .pulse_out_pin_oe,
    .period_match_irq, .irq);
